/* File: logic/pcd_pkg.sv */
// Constants and carrier types for the configuration access decoder.
package pcd_pkg;
  localparam logic [15:0] PCD_SEL_PORT = 16'h0CF8;
  localparam logic [15:0] PCD_DATA_PORT = 16'h0CFC;
  localparam logic [31:0] PCD_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] PCD_SEL_MASK = 32'h80FF_FFFC;
  localparam int PCD_EN_BIT = 31;
  localparam int PCD_BUS_HI = 23;
  localparam int PCD_BUS_LO = 16;
  localparam int PCD_DEV_HI = 15;
  localparam int PCD_DEV_LO = 11;
  localparam int PCD_FUN_HI = 10;
  localparam int PCD_FUN_LO = 8;
  localparam int PCD_REG_HI = 7;
  localparam int PCD_REG_LO = 2;
  localparam logic [7:0] PCD_BUS_ZERO = 8'h00;
  localparam logic [4:0] PCD_LAST_INT_DEV = 5'h01;
  localparam logic [2:0] PCD_FUNC_ZERO = 3'h0;
  localparam logic [3:0] PCD_BE_DWORD = 4'hF;
  localparam logic [31:0] PCD_ZERO_WORD = 32'h0000_0000;

  // Kind of cycle driven onto the downstream link.
  typedef enum logic [1:0] {
    PCD_DN_IO_RD = 2'h0,
    PCD_DN_IO_WR = 2'h1,
    PCD_DN_CFG_RD = 2'h2,
    PCD_DN_CFG_WR = 2'h3
  } pcd_dn_kind_t;

  // Host I/O request.
  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcd_io_req_t;

  // Downstream link request; addr carries bus, device, function, register for configuration kinds, the I/O port for I/O kinds.
  typedef struct packed {
    pcd_dn_kind_t kind;
    logic [31:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcd_dn_req_t;

  // Internal configuration space request.
  typedef struct packed {
    logic wr;
    logic dev;
    logic [5:0] regnum;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcd_int_req_t;
endpackage

/* File: logic/pcd_sync.sv */
// Three-stage synchroniser whose output moves when the last two agree.
`timescale 1ns/1ps
module pcd_sync import pcd_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        q_next[i] = s2_reg[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

/* File: logic/pcd_int_cfg.sv */
// Internal configuration space of devices 0 and 1, function 0.
`timescale 1ns/1ps
module pcd_int_cfg import pcd_pkg::*; #(
  parameter int WORDS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Strap defaults, caught when reset releases
  input wire logic [31:0] strap_word,
  // Request
  input wire logic req_valid,
  input wire pcd_int_req_t req,
  // Answer, one cycle after the request
  output logic ack,
  output logic [31:0] rdata
);
  logic [31:0] mem_reg [2][WORDS];
  logic [31:0] mem_next [2][WORDS];
  logic loaded_reg, loaded_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;

  function automatic logic [31:0] pcd_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    mem_next = mem_reg;
    loaded_next = 1'b1;
    ack_next = req_valid;
    rdata_next = PCD_ZERO_WORD;
    if (!loaded_reg) begin
      mem_next[0][0] = strap_word;
    end
    if (req_valid) begin
      if (req.wr) begin
        mem_next[req.dev][req.regnum] =
          pcd_merge(mem_reg[req.dev][req.regnum], req.wdata, req.be);
      end else begin
        rdata_next = pcd_merge(PCD_ZERO_WORD,
          mem_reg[req.dev][req.regnum], req.be);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int d = 0; d < 2; d++) begin
        for (int w = 0; w < WORDS; w++) begin
          mem_reg[d][w] <= PCD_ZERO_WORD;
        end
      end
      loaded_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= PCD_ZERO_WORD;
    end else begin
      mem_reg <= mem_next;
      loaded_reg <= loaded_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ack = ack_reg;
  assign rdata = rdata_reg;
endmodule

/* File: logic/pcd_decoder.sv */
// Configuration selector and data window decoder with downstream routing.
`timescale 1ns/1ps
module pcd_decoder import pcd_pkg::*; #(
  parameter int CFG_WORDS = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Straps and internal device enables from outside the clock domain
  input wire logic [31:0] strap_word,
  input wire logic [1:0] int_dev_enable,
  // Host I/O port
  input wire logic io_valid,
  input wire pcd_io_req_t io_req,
  output logic io_ready,
  output logic io_done,
  output logic [31:0] io_rdata,
  // Downstream link
  output logic dn_valid,
  output pcd_dn_req_t dn_req,
  input wire logic dn_done,
  input wire logic [31:0] dn_rdata,
  // Status
  output logic config_access_enable
);
  typedef enum logic [3:0] {
    PCD_IDLE = 4'b0001,
    PCD_INT = 4'b0010,
    PCD_DOWN = 4'b0100,
    PCD_DONE = 4'b1000
  } pcd_state_t;

  logic rst_a_reg, rst_b_reg;
  logic rst_a_next, rst_b_next;
  logic rst_n;
  logic ready_reg, ready_next;
  logic [1:0] dev_en;

  pcd_state_t state_reg, state_next;
  logic [31:0] sel_reg, sel_next;
  logic done_reg, done_next;
  logic [31:0] rdata_reg, rdata_next;
  logic dn_valid_reg, dn_valid_next;
  pcd_dn_req_t dn_req_reg, dn_req_next;
  logic int_valid;
  pcd_int_req_t int_req;
  logic int_ack;
  logic [31:0] int_rdata;

  logic hit_sel, hit_data, sel_dword, to_cfg, bus0, dev_int, internal;
  logic [4:0] sel_dev;

  // Reset release through two flops; assertion stays asynchronous.
  always_comb begin
    rst_a_next = 1'b1;
    rst_b_next = rst_a_reg;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= rst_a_next;
      rst_b_reg <= rst_b_next;
    end
  end
  assign rst_n = rst_b_reg;

  pcd_sync #(.WIDTH(2)) u_en_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(int_dev_enable),
    .q(dev_en)
  );

  pcd_int_cfg #(.WORDS(CFG_WORDS)) u_int_cfg (
    .clk(clk),
    .rst_n(rst_n),
    .strap_word(strap_word),
    .req_valid(int_valid),
    .req(int_req),
    .ack(int_ack),
    .rdata(int_rdata)
  );

  // Both forwarding paths share one kind decode, so they cannot drift apart.
  function automatic pcd_dn_kind_t pcd_fwd_kind(input logic cfg,
      input logic wr);
    pcd_dn_kind_t k;
    if (cfg) begin
      k = wr ? PCD_DN_CFG_WR : PCD_DN_CFG_RD;
    end else begin
      k = wr ? PCD_DN_IO_WR : PCD_DN_IO_RD;
    end
    return k;
  endfunction

  // Only the doubleword selector and data ports are decoded; there is no
  // second forwarding-register mechanism at any other port.
  always_comb begin
    hit_sel = io_req.addr == PCD_SEL_PORT;
    hit_data = io_req.addr == PCD_DATA_PORT;
    sel_dword = io_req.be == PCD_BE_DWORD;
    to_cfg = sel_reg[PCD_EN_BIT];
    bus0 = sel_reg[PCD_BUS_HI:PCD_BUS_LO] == PCD_BUS_ZERO;
    sel_dev = sel_reg[PCD_DEV_HI:PCD_DEV_LO];
    dev_int = bus0 && (sel_dev <= PCD_LAST_INT_DEV);
    internal = dev_int && dev_en[sel_dev[0]];
  end

  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    dn_valid_next = dn_valid_reg;
    dn_req_next = dn_req_reg;
    int_valid = 1'b0;
    int_req = '0;
    case (state_reg)
      PCD_IDLE: begin
        if (io_valid) begin
          if (hit_sel && sel_dword) begin
            if (io_req.wr) begin
              sel_next = io_req.wdata & PCD_SEL_MASK;
            end
            rdata_next = sel_reg;
            state_next = PCD_DONE;
          end else if (hit_data && to_cfg && internal) begin
            if (sel_reg[PCD_FUN_HI:PCD_FUN_LO] != PCD_FUNC_ZERO) begin
              rdata_next = PCD_ZERO_WORD;
              state_next = PCD_DONE;
            end else begin
              int_valid = 1'b1;
              int_req.wr = io_req.wr;
              int_req.dev = sel_dev[0];
              int_req.regnum = sel_reg[PCD_REG_HI:PCD_REG_LO];
              int_req.be = io_req.be;
              int_req.wdata = io_req.wdata;
              state_next = PCD_INT;
            end
          end else begin
            dn_valid_next = 1'b1;
            dn_req_next.be = io_req.be;
            dn_req_next.wdata = io_req.wdata;
            dn_req_next.kind = pcd_fwd_kind(hit_data && to_cfg,
              io_req.wr);
            if (hit_data && to_cfg) begin
              // Bus, device, function and register travel in place.
              dn_req_next.addr = sel_reg & PCD_SEL_MASK;
            end else begin
              dn_req_next.addr = {16'h0000, io_req.addr};
            end
            state_next = PCD_DOWN;
          end
        end
      end
      PCD_INT: begin
        if (int_ack) begin
          rdata_next = int_rdata;
          state_next = PCD_DONE;
        end
      end
      PCD_DOWN: begin
        if (dn_done) begin
          dn_valid_next = 1'b0;
          rdata_next = dn_rdata;
          state_next = PCD_DONE;
        end
      end
      PCD_DONE: begin
        done_next = 1'b1;
        state_next = PCD_IDLE;
      end
      default: begin
        state_next = PCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PCD_IDLE;
      sel_reg <= PCD_SEL_RESET;
      done_reg <= 1'b0;
      rdata_reg <= PCD_ZERO_WORD;
      dn_valid_reg <= 1'b0;
      dn_req_reg <= '0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      dn_valid_reg <= dn_valid_next;
      dn_req_reg <= dn_req_next;
    end
  end

  // Ready mirrors the idle state, so it falls at the edge of a take.
  always_comb begin
    ready_next = state_next == PCD_IDLE;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  assign io_ready = ready_reg;
  assign io_done = done_reg;
  assign io_rdata = rdata_reg;
  assign dn_valid = dn_valid_reg;
  assign dn_req = dn_req_reg;
  assign config_access_enable = sel_reg[PCD_EN_BIT];
endmodule

/* File: tb/pcd_hub_model.sv */
// Behavioural model of the downstream hub answering forwarded cycles.
`timescale 1ns/1ps
module pcd_hub_model import pcd_pkg::*; (
  input wire logic clk,
  input wire logic dn_valid,
  input wire pcd_dn_req_t dn_req,
  input wire logic [3:0] lag,
  output logic dn_done,
  output logic [31:0] dn_rdata
);
  int cnt = 0;
  initial begin
    dn_done = 1'b0;
    dn_rdata = 32'h0;
  end
  // Read data follows the address so the bench can predict it; between
  // answers the data lines toggle so stale values never look valid.
  always @(posedge clk) begin
    #1;
    if (dn_valid && !dn_done && cnt >= lag) begin
      dn_done = 1'b1;
      dn_rdata = dn_req.addr ^ 32'hA5A5_5A5A;
      cnt = 0;
    end else begin
      dn_done = 1'b0;
      dn_rdata = ~dn_rdata;
      if (dn_valid) cnt++;
    end
  end
endmodule

/* File: tb/pcd_decoder_properties.sv */
// Port assertions for the configuration access decoder.
`timescale 1ns/1ps
module pcd_decoder_chk import pcd_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] int_dev_enable,
  input wire logic io_valid,
  input wire pcd_io_req_t io_req,
  input wire logic io_ready,
  input wire logic io_done,
  input wire logic [31:0] io_rdata,
  input wire logic dn_valid,
  input wire pcd_dn_req_t dn_req,
  input wire logic dn_done,
  input wire logic config_access_enable
);
  logic [31:0] sel_reg, sel_next;
  logic take, sel_wr, dat, inner, loc, zf;
  assign take = io_valid && io_ready;
  assign sel_wr = take && io_req.wr && io_req.addr == PCD_SEL_PORT &&
    io_req.be == PCD_BE_DWORD;
  assign dat = take && io_req.addr == PCD_DATA_PORT && config_access_enable;
  assign inner = sel_reg[23:16] == 8'h00 && sel_reg[15:11] <= 5'h01;
  assign loc = inner && int_dev_enable[sel_reg[11]];
  assign zf = sel_reg[10:8] == 3'h0;
  always_comb sel_next = sel_wr ? io_req.wdata & PCD_SEL_MASK : sel_reg;
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) sel_reg <= 32'h0;
    else sel_reg <= sel_next;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_sel_wr;
    sel_wr |-> ##2 io_done &&
      config_access_enable == $past(io_req.wdata[31], 2);
  endproperty
  a_sel_wr: assert property (p_sel_wr)
    else $error("selector write");
  property p_sel_quiet; sel_wr |=> !dn_valid [*2]; endproperty
  a_sel_quiet: assert property (p_sel_quiet)
    else $error("selector leak");
  property p_sel_part;
    take && io_req.addr == PCD_SEL_PORT && io_req.be != PCD_BE_DWORD |=>
      dn_valid && !dn_req.kind[1] && dn_req.addr == 32'h0000_0CF8;
  endproperty
  a_sel_part: assert property (p_sel_part)
    else $error("partial selector");
  property p_io_off;
    take && io_req.addr == PCD_DATA_PORT && !config_access_enable |=>
      dn_valid && !dn_req.kind[1];
  endproperty
  a_io_off: assert property (p_io_off)
    else $error("disabled data port");
  property p_cfg_fwd;
    dat && (!inner || (!int_dev_enable[sel_reg[11]] && zf)) |=> dn_valid &&
      dn_req.kind[1] && dn_req.kind[0] == $past(io_req.wr) &&
      dn_req.addr == sel_reg;
  endproperty
  a_cfg_fwd: assert property (p_cfg_fwd)
    else $error("forwarded cycle");
  property p_int_local;
    dat && loc && zf |-> ##1 !dn_valid ##1 !dn_valid ##1 io_done;
  endproperty
  a_int_local: assert property (p_int_local)
    else $error("internal cycle");
  property p_fn_ign;
    dat && loc && !zf && !io_req.wr |-> ##2 io_done &&
      io_rdata == PCD_ZERO_WORD;
  endproperty
  a_fn_ign: assert property (p_fn_ign)
    else $error("function not zero");
  property p_dn_hold;
    dn_valid && !dn_done |=> dn_valid && $stable(dn_req);
  endproperty
  a_dn_hold: assert property (p_dn_hold)
    else $error("downstream dropped");
  property p_dn_ans; dn_valid && dn_done |-> ##2 io_done; endproperty
  a_dn_ans: assert property (p_dn_ans)
    else $error("late answer");
  property p_busy; take |=> !io_ready; endproperty
  a_busy: assert property (p_busy)
    else $error("ready while busy");
  c_sel: cover property (sel_wr);
  c_loc: cover property (dat && loc);
  c_dn: cover property (dn_valid && dn_done);
  c_fn: cover property (dat && loc && !zf);
endmodule
bind pcd_decoder pcd_decoder_chk chk (.clk(clk), .reset_n(reset_n),
  .int_dev_enable(int_dev_enable), .io_valid(io_valid), .io_req(io_req),
  .io_ready(io_ready), .io_done(io_done), .io_rdata(io_rdata),
  .dn_valid(dn_valid), .dn_req(dn_req), .dn_done(dn_done),
  .config_access_enable(config_access_enable));

/* File: tb/tb.sv */
// Self-checking bench for the configuration access decoder.
`timescale 1ns/1ps
module tb import pcd_pkg::*; ;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] strap_word = 32'h1234_ABCD;
  logic [1:0] int_dev_enable = 2'h1;
  logic io_valid = 1'b0;
  pcd_io_req_t io_req = '0;
  logic io_ready, io_done, dn_valid, dn_done, cae, got, fw;
  logic [31:0] io_rdata, dn_rdata, sel, rd, got_a, d;
  pcd_dn_req_t dn_req;
  logic [1:0] got_k;
  logic [3:0] lag = 4'h0;
  logic [3:0] be;
  logic [31:0] mem [0:127];
  int err_total = 0;
  int total_checks = 0;
  pcd_decoder dut (.clk(clk), .reset_n(reset_n), .strap_word(strap_word),
    .int_dev_enable(int_dev_enable), .io_valid(io_valid), .io_req(io_req),
    .io_ready(io_ready), .io_done(io_done), .io_rdata(io_rdata),
    .dn_valid(dn_valid), .dn_req(dn_req), .dn_done(dn_done),
    .dn_rdata(dn_rdata), .config_access_enable(cae));
  pcd_hub_model hub (.clk(clk), .dn_valid(dn_valid), .dn_req(dn_req),
    .lag(lag), .dn_done(dn_done), .dn_rdata(dn_rdata));
  initial forever #2.5 clk = ~clk;
  task automatic print_verdict;
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] lanes(input logic [3:0] b);
    return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
  endfunction
  // The request is dropped in the cycle io_done shows, so it is not taken
  // a second time.
  task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b,
      input logic [31:0] wd);
    int n;
    n = 0;
    got = 1'b0;
    @(posedge clk);
    #1;
    check("io_ready", {31'h0, io_ready}, 32'h1);
    io_req = '{w, a, b, wd};
    io_valid = 1'b1;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (dn_valid) begin
        got = 1'b1;
        got_k = dn_req.kind;
        got_a = dn_req.addr;
      end
    end while (io_done !== 1'b1 && n < 60);
    io_valid = 1'b0;
    rd = io_rdata;
    check("io_done", {31'h0, io_done}, 32'h1);
  endtask
  initial begin
    int idx;
    void'($urandom(32'h426B));
    foreach (mem[i]) mem[i] = 32'h0;
    mem[0] = strap_word;
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (10) @(posedge clk);
    acc(0, PCD_SEL_PORT, 4'hF, 0);
    check("sel reset", rd, PCD_SEL_RESET);
    check("enable off", {31'h0, cae}, 32'h0);
    acc(1, PCD_SEL_PORT, 4'h3, 32'hFFFF_FFFF);
    check("partial", {13'h0, got, got_k, got_a[15:0]}, 32'h0005_0CF8);
    acc(0, PCD_DATA_PORT, 4'hF, 0);
    check("io route", {13'h0, got, got_k, got_a[15:0]}, 32'h0004_0CFC);
    check("io data", rd, 32'h0000_0CFC ^ 32'hA5A5_5A5A);
    for (int p = 0; p < 4; p++) begin
      int_dev_enable = 2'(p);
      repeat (10) @(posedge clk);
      for (int k = 0; k < 40; k++) begin
        sel = ($urandom & PCD_SEL_MASK) | 32'h8000_0000;
        if (k % 4 != 3) sel[23:16] = 8'h00;
        if (k % 4 != 0) sel[15:11] = 5'($urandom % 3);
        if (k % 3 != 0) sel[10:8] = 3'h0;
        fw = !(sel[23:16] == 8'h00 && sel[15:11] <= 5'h01 &&
          int_dev_enable[sel[11]]);
        if (fw && sel[23:16] == 8'h00 && sel[15:11] <= 5'h01) sel[10:8] = 3'h0;
        idx = {sel[11], sel[7:2]};
        acc(1, PCD_SEL_PORT, 4'hF, sel | 32'h7F00_0003);
        check("enable", {31'h0, cae}, {31'h0, sel[31]});
        acc(0, PCD_SEL_PORT, 4'hF, 0);
        check("selector", rd, sel);
        for (int w = 1; w >= 0; w--) begin
          be = 4'($urandom);
          lag = 4'($urandom % 4);
          d = $urandom;
          acc(w[0], PCD_DATA_PORT, be, d);
          check("route", {31'h0, got}, {31'h0, fw});
          if (fw) begin
            check("dn addr", got_a, sel);
            check("dn kind", {30'h0, got_k}, {30'h0, 1'b1, w[0]});
          end else if (w && sel[10:8] == 3'h0) begin
            mem[idx] = (mem[idx] & ~lanes(be)) | (d & lanes(be));
          end
          if (w == 0) check("data", rd & lanes(be), (fw ? sel ^ 32'hA5A5_5A5A :
            sel[10:8] != 3'h0 ? 32'h0 : mem[idx]) & lanes(be));
        end
      end
    end
    print_verdict;
  end
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
endmodule
